/* rac_alarm_compare.v */
// rac_alarm_compare.v: alarm registers, compare logic, flag and interrupt
// assumes: time counters arrive synchronous to clock, avalon master on clock
//
// Operation
// - compare only enabled fields; set flag when all enabled fields match together
// - second alarm: enable bit 7, tens bits 6..4, units bits 3..0, read/write
// - minute alarm: enable bit 7, tens 6..4, units 3..0, against minute counter
// - hour alarm: enable bit 7, bit 6 reads zero, tens 5..4, units 3..0
// - weekday alarm: enable bit 7, bits 6..3 read zero, code bits 2..0
// - date alarm: enable bit 7, bit 6 reads zero, tens 5..4, units 3..0
// - reset clears every compare enable bit
// - alarm value fields keep contents across reset, undefined until written
// - reserved alarm register bits always read zero
// - alarm interrupt raised when flag set and interrupt enable set
// - weekday counter uses 000 Sunday to 110 Saturday, 111 prohibited
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.vh"

module rac_alarm_compare #(
    parameter NUM_FIELDS = 5
) (
    input wire clock,
    input wire resetn,
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [6:0] second_counter,
    input wire [6:0] minute_counter,
    input wire [5:0] hour_counter,
    input wire [2:0] weekday_counter,
    input wire [5:0] date_counter,
    output wire alarm_flag,
    output wire alarm_irq
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function [6:0] field_mask;
        input integer idx;
        begin
            case (idx)
                0: field_mask = `RAC_SEC_MASK;
                1: field_mask = `RAC_MIN_MASK;
                2: field_mask = `RAC_HOUR_MASK;
                3: field_mask = `RAC_WDAY_MASK;
                4: field_mask = `RAC_DATE_MASK;
                default: field_mask = 7'h00;
            endcase
        end
    endfunction

    function [2:0] field_addr;
        input integer idx;
        begin
            case (idx)
                0: field_addr = `RAC_ADDR_SEC;
                1: field_addr = `RAC_ADDR_MIN;
                2: field_addr = `RAC_ADDR_HOUR;
                3: field_addr = `RAC_ADDR_WDAY;
                default: field_addr = `RAC_ADDR_DATE;
            endcase
        end
    endfunction

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    reg ack_q;
    reg ack_d;
    wire req;
    wire wr_take;
    wire rd_take;

    assign req = avs_read | avs_write;
    // one wait cycle per access, answer on the second edge
    assign avs_waitrequest = req & ~ack_q;
    // write lands at the edge that ends the answer cycle
    assign wr_take = avs_write & ack_q;
    // read data loaded one edge early, stands at the answer edge
    assign rd_take = avs_read & ~ack_q;

    // ack for one cycle, then low so the next request waits again
    always @* begin
        ack_d = 1'h0;
        if (req && !ack_q) begin
            ack_d = 1'h1;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'h0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire [NUM_FIELDS-1:0] field_sel;
    wire status_sel;
    wire mask_sel;
    wire status_wr;
    wire mask_wr;

    assign status_sel = (avs_address == `RAC_ADDR_STATUS);
    assign mask_sel = (avs_address == `RAC_ADDR_MASK);
    assign status_wr = wr_take & status_sel;
    assign mask_wr = wr_take & mask_sel;

    // ****************************************************************
    // alarm registers
    // ****************************************************************
    wire [6:0] counter_vec [0:NUM_FIELDS-1];
    assign counter_vec[0] = second_counter;
    assign counter_vec[1] = minute_counter;
    assign counter_vec[2] = {1'h0, hour_counter};
    assign counter_vec[3] = {4'h0, weekday_counter};
    assign counter_vec[4] = {1'h0, date_counter};

    wire [NUM_FIELDS-1:0] enable_vec;
    wire [NUM_FIELDS-1:0] field_hit;
    wire [NUM_FIELDS-1:0] field_moved;
    wire [7:0] field_rd [0:NUM_FIELDS-1];

    genvar g;
    generate
        for (g = 0; g < NUM_FIELDS; g = g + 1) begin : gen_field
            reg enable_q;
            reg enable_d;
            reg [6:0] value_q;
            reg [6:0] value_d;
            reg [6:0] count_last_q;
            wire sel;
            wire [6:0] value_cut;
            wire [6:0] count_cut;

            assign field_sel[g] = (avs_address == field_addr(g));
            assign sel = wr_take & field_sel[g];
            // only implemented value bits take part
            assign value_cut = value_q & field_mask(g);
            assign count_cut = counter_vec[g] & field_mask(g);

            always @* begin
                enable_d = enable_q;
                value_d = value_q;
                if (sel) begin
                    enable_d = avs_writedata[`RAC_ENABLE_BIT];
                    value_d = avs_writedata[6:0] & field_mask(g);
                end
            end

            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    enable_q <= `RAC_ENABLE_RST;
                end else begin
                    enable_q <= enable_d;
                end
            end

            // value kept across reset
            always @(posedge clock) begin
                value_q <= value_d;
            end

            // last counter value, for change detection
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    count_last_q <= 7'h0;
                end else begin
                    count_last_q <= count_cut;
                end
            end

            assign enable_vec[g] = enable_q;
            assign field_moved[g] = (count_cut != count_last_q);
            // reserved bits forced to zero
            assign field_rd[g] = {enable_q, value_cut};
            // disabled field always agrees
            assign field_hit[g] = ~enable_q | (value_cut == count_cut);
        end
    endgenerate

    // ****************************************************************
    // match, flag and interrupt
    // ****************************************************************
    reg match_last_q;
    reg flag_q;
    reg flag_d;
    reg irq_en_q;
    reg irq_en_d;
    wire time_changed;
    wire match_now;
    wire match_rise;
    wire set_flag;
    wire clr_flag;

    // any counter moved since the last edge
    assign time_changed = |field_moved;
    assign match_now = (|enable_vec) & (&field_hit);
    assign match_rise = match_now & ~match_last_q;
    // evaluated on every counter change
    assign set_flag = match_rise | (match_now & time_changed);
    assign clr_flag = status_wr & avs_writedata[`RAC_FLAG_BIT];

    // set wins over clear
    always @* begin
        flag_d = flag_q;
        if (set_flag) begin
            flag_d = 1'h1;
        end else if (clr_flag) begin
            flag_d = 1'h0;
        end
    end

    always @* begin
        irq_en_d = irq_en_q;
        if (mask_wr) begin
            irq_en_d = avs_writedata[`RAC_FLAG_BIT];
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            match_last_q <= 1'h0;
            flag_q <= `RAC_FLAG_RST;
            irq_en_q <= `RAC_MASK_RST;
        end else begin
            match_last_q <= match_now;
            flag_q <= flag_d;
            irq_en_q <= irq_en_d;
        end
    end

    assign alarm_flag = flag_q;
    assign alarm_irq = flag_q & irq_en_q;

    // ****************************************************************
    // read data
    // ****************************************************************
    reg [31:0] rd_d;
    reg [31:0] readdata_d;
    integer i;

    // unmapped address falls through to zero
    always @* begin
        rd_d = 32'h0;
        for (i = 0; i < NUM_FIELDS; i = i + 1) begin
            if (field_sel[i]) begin
                rd_d = {24'h0, field_rd[i]};
            end
        end
        if (status_sel) begin
            rd_d = {31'h0, flag_q};
        end
        if (mask_sel) begin
            rd_d = {31'h0, irq_en_q};
        end
    end

    always @* begin
        readdata_d = avs_readdata;
        if (rd_take) begin
            readdata_d = rd_d;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0;
        end else begin
            avs_readdata <= readdata_d;
        end
    end

endmodule
`default_nettype wire

/* rac_defs.vh */
// rac_defs.vh: offsets, field positions, reset values of the alarm compare block
// assumes: included by rac_alarm_compare.v, word addressed avalon slave
`ifndef RAC_DEFS_VH
`define RAC_DEFS_VH

// ********************************************************************
// register word addresses
// ********************************************************************
`define RAC_ADDR_SEC 3'h0
`define RAC_ADDR_MIN 3'h1
`define RAC_ADDR_HOUR 3'h2
`define RAC_ADDR_WDAY 3'h3
`define RAC_ADDR_DATE 3'h4
`define RAC_ADDR_STATUS 3'h5
`define RAC_ADDR_MASK 3'h6

// ********************************************************************
// field positions and masks
// ********************************************************************
`define RAC_ENABLE_BIT 7
`define RAC_SEC_MASK 7'h7F
`define RAC_MIN_MASK 7'h7F
`define RAC_HOUR_MASK 7'h3F
`define RAC_WDAY_MASK 7'h07
`define RAC_DATE_MASK 7'h3F
`define RAC_FLAG_BIT 0

// ********************************************************************
// reset values
// ********************************************************************
`define RAC_ENABLE_RST 1'h0
`define RAC_FLAG_RST 1'h0
`define RAC_MASK_RST 1'h0

`endif

/* rac_alarm_compare_monitor.sv */
// rac_alarm_compare_monitor.sv: port assertions of the alarm compare block
// assumes: bound to rac_alarm_compare, rac_defs.vh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.vh"

module rac_alarm_compare_monitor (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic alarm_flag,
    input wire logic alarm_irq
);
    // ****************
    // bus and flag checks
    // ****************
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence req_done;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    chk_wait_one: assert property (req_wait |=> req_done)
        else $error("request not answered after one wait cycle");
    chk_reset_clear: assert property ($rose(resetn) |-> !alarm_flag && !alarm_irq)
        else $error("flag or irq set right after reset");
    chk_irq_gate: assert property (alarm_irq |-> alarm_flag)
        else $error("irq without flag");
    chk_irq_masked: assert property (req_done ##0 (avs_write && !avs_writedata[0]
        && avs_address == `RAC_ADDR_MASK) |=> !alarm_irq)
        else $error("irq high after mask cleared");
    chk_flag_sticky: assert property (alarm_flag && !(avs_write && !avs_waitrequest
        && avs_address == `RAC_ADDR_STATUS && avs_writedata[0]) |=> alarm_flag)
        else $error("flag dropped without clear");
    chk_unmapped_zero: assert property (rd_done ##0 (avs_address == 3'h7)
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_wday_resv: assert property (rd_done ##0 (avs_address == `RAC_ADDR_WDAY)
        |-> avs_readdata[6:3] == 4'h0)
        else $error("weekday reserved bits not zero");
    chk_hour_resv: assert property (rd_done ##0 (avs_address == `RAC_ADDR_HOUR
        || avs_address == `RAC_ADDR_DATE) |-> !avs_readdata[6])
        else $error("hour or date reserved bit not zero");
endmodule

bind rac_alarm_compare rac_alarm_compare_monitor i_mon (.clock, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .alarm_flag,
    .alarm_irq);
`default_nettype wire

/* testbench.sv */
// testbench.sv: self-checking bench of the alarm compare block
// assumes: rac_alarm_compare.v and rac_defs.vh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.vh"
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end

module testbench;
    logic clock = 0, resetn = 0, avs_read = 0, avs_write = 0;
    logic alarm_flag, alarm_irq, avs_waitrequest;
    logic [2:0] avs_address = 0, weekday_counter = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd_q;
    logic [6:0] second_counter = 0, minute_counter = 0;
    logic [5:0] hour_counter = 0, date_counter = 0;
    int fail_count = 0, cmp_count = 0;
    rac_alarm_compare i_dut (.clock, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .second_counter, .minute_counter,
        .hour_counter, .weekday_counter, .date_counter, .alarm_flag, .alarm_irq);
    initial forever #5 clock = ~clock;
    // ****************
    // tasks
    // ****************
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        logic b;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(negedge clock);
            b = avs_waitrequest;
            rd_q = avs_readdata;
            @(posedge clock);
            n++;
        end while (b !== 1'b0 && n < 20);
        avs_write <= 0;
        avs_read <= 0;
        `CMP(b, 1'b0)
        if (b !== 1'b0) print_verdict;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        xfer(1, a, d);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        xfer(0, a, 8'h0);
        `CMP(rd_q, {24'h0, e})
    endtask
    task cnt(input logic [6:0] s, input logic [5:0] h, input logic [2:0] w, input logic [5:0] d);
        @(posedge clock);
        second_counter <= s;
        minute_counter <= s;
        hour_counter <= h;
        weekday_counter <= w;
        date_counter <= d;
    endtask
    task fl(input logic f, input logic i);
        repeat (2) @(posedge clock);
        #1;
        `CMP({alarm_flag, alarm_irq}, {f, i})
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1;
        for (int a = 0; a < 5; a++) begin
            xfer(0, a[2:0], 8'h0);
            `CMP(rd_q[7], 1'b0)
        end
        rd(`RAC_ADDR_STATUS, 8'h00);
        rd(`RAC_ADDR_MASK, 8'h00);
        wr(0, 8'hD9); rd(0, 8'hD9);
        wr(1, 8'h59); rd(1, 8'h59);
        wr(2, 8'hFF); rd(2, 8'hBF);
        wr(3, 8'hFF); rd(3, 8'h87);
        wr(4, 8'hFF); rd(4, 8'hBF);
        wr(7, 8'hFF); rd(7, 8'h00);
        $display("test registers done");
        wr(0, 8'h59); wr(2, 8'h23); wr(4, 8'h31); wr(6, 8'h01);
        for (int c = 0; c < 7; c++) begin
            cnt(0, 0, 3'((c + 1) % 7), 0);
            wr(3, {5'h10, c[2:0]}); fl(0, 0);
            cnt(0, 0, c[2:0], 0); fl(1, 1);
            wr(5, 8'h01); fl(0, 0);
        end
        $display("test weekday codes done");
        wr(0, 8'hD9); wr(1, 8'hD9); wr(2, 8'hA3); wr(3, 8'h86); wr(4, 8'hB1);
        wr(6, 8'h00);
        cnt(7'h59, 6'h23, 3'h6, 6'h21); fl(0, 0);
        cnt(7'h59, 6'h23, 3'h6, 6'h31); fl(1, 0);
        wr(6, 8'h01); fl(1, 1);
        wr(5, 8'h01); fl(0, 0);
        cnt(7'h58, 6'h23, 3'h6, 6'h31); cnt(7'h59, 6'h23, 3'h6, 6'h31); fl(1, 1);
        $display("test all fields done");
        wr(5, 8'h01); wr(0, 8'h59); wr(1, 8'h59); wr(2, 8'h23); wr(3, 8'h06); wr(4, 8'h31);
        cnt(7'h58, 6'h23, 3'h6, 6'h31); cnt(7'h59, 6'h23, 3'h6, 6'h31); fl(0, 0);
        $display("test no enables done");
        wr(0, 8'hD9);
        @(posedge clock) resetn <= 0;
        repeat (2) @(posedge clock);
        resetn <= 1;
        rd(0, 8'h59);
        fl(0, 0);
        $display("test mid-run reset done");
        print_verdict;
    end
endmodule
`default_nettype wire
